//--- src/uart_wake_break_sync_master.sv
// The AXI4-Lite interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module uart_wake_break_sync_master
   import uart_wake_pkg::*;
(
   // Clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        clk_en,
   // AXI4-Lite write
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // AXI4-Lite read
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Serial pins
   input  wire logic        rx_pin,
   output logic             tx_pin,
   output logic             shift_clock_pin,
   output logic             data_line_pin_o,
   output logic             data_line_pin_oe_n
);
   import uart_wake_pkg::*;

   typedef enum {TX_IDLE, TX_SHIFT} tx_state_t;

   logic [7:0]  rx_ctrl_r, tx_ctrl_r, baud_r, div_hi_r, div_lo_r, tx_buf_r, rx_buf_r;
   logic        tx_buf_full_r, rx_flag_r, tx_flag_r;
   logic [1:0]  rx_sync_r;
   logic        rx_prev_r, wake_seen_r;
   logic [15:0] baud_cnt_r;
   logic        half_tick;
   logic        phase_r;
   logic [4:0]  bit_cnt_r;
   logic [4:0]  bit_total_r;
   logic [9:0]  tx_shift_reg_r;
   logic        is_break_r;
   tx_state_t   tx_state_r;
   logic        aw_ok_r, w_ok_r;
   logic [7:0]  aw_addr_r;
   logic [31:0] w_data_r;
   logic [3:0]  w_strb_r;
   logic        rd_buf_pulse, wr_buf_pulse, load_now, bit_end;
   logic        clocked_mode, wake_en, rx_fall, rx_rise, send_brk;
   logic        idle_clk, idle_dat;

   function automatic logic known_addr(input logic [7:0] a);
      known_addr = (a <= FLAGS_ADDR) && (a[1:0] == 2'h0);
   endfunction : known_addr

   // Master clocked mode select
   assign clocked_mode = tx_ctrl_r[CLK_SRC_BIT] && tx_ctrl_r[CLOCKED_BIT]
                         && rx_ctrl_r[PORT_EN_BIT];
   assign wake_en  = baud_r[WAKE_EN_BIT];
   assign idle_clk = baud_r[CLK_POL_BIT];
   assign idle_dat = baud_r[DATA_POL_BIT];

   // Receive pin synchroniser
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rx_sync_r <= 2'h3;
         rx_prev_r <= 1'b1;
      end else if (clk_en) begin
         rx_sync_r <= {rx_sync_r[0], rx_pin};
         rx_prev_r <= rx_sync_r[1];
      end
   end
   assign rx_fall = rx_prev_r && !rx_sync_r[1];
   assign rx_rise = !rx_prev_r && rx_sync_r[1];

   // AXI write channel capture, either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_ok_r  <= 1'b0;
         w_ok_r   <= 1'b0;
         aw_addr_r <= 8'h00;
         w_data_r <= 32'h0;
         w_strb_r <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end else if (clk_en) begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_ok_r  <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_ok_r   <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
         end
         if (aw_ok_r && w_ok_r && !s_axi_bvalid) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= known_addr(aw_addr_r) ? RESP_OKAY : RESP_SLVERR;
            aw_ok_r <= 1'b0;
            w_ok_r  <= 1'b0;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
      end else if (clk_en) begin
         s_axi_awready <= !aw_ok_r && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
         s_axi_wready  <= !w_ok_r && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
      end
   end

   logic wr_go;
   assign wr_go = clk_en && aw_ok_r && w_ok_r && !s_axi_bvalid && w_strb_r[0];
   assign wr_buf_pulse = wr_go && (aw_addr_r == TX_BUF_ADDR);

   // Baud rate generator: half-bit ticks
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         baud_cnt_r <= 16'h0;
      end else if (clk_en) begin
         baud_cnt_r <= (half_tick || tx_state_r == TX_IDLE) ? 16'h0 : baud_cnt_r + 16'h1;
      end
   end
   assign half_tick = (baud_cnt_r >= {div_hi_r, div_lo_r});

   assign bit_end  = half_tick && phase_r && tx_state_r == TX_SHIFT;
   // Reload at the end of a break carries the queued byte, not a second break
   assign send_brk = tx_ctrl_r[BREAK_BIT] && !clocked_mode
                     && !(tx_state_r == TX_SHIFT && is_break_r);
   // Half-duplex: no load while wake or receive activity
   assign load_now = clk_en && tx_buf_full_r && tx_ctrl_r[TX_EN_BIT] && !wake_seen_r
                     && (tx_state_r == TX_IDLE
                         || (bit_end && bit_cnt_r == bit_total_r - 5'h1));

   // Control registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rx_ctrl_r <= REG_RESET;
         tx_ctrl_r <= TX_CTRL_RESET;
         baud_r    <= BAUD_RESET;
         div_hi_r  <= REG_RESET;
         div_lo_r  <= REG_RESET;
      end else if (clk_en) begin
         if (wr_go && aw_addr_r == RX_CTRL_ADDR) rx_ctrl_r <= w_data_r[7:0];
         if (wr_go && aw_addr_r == DIV_HI_ADDR) div_hi_r <= w_data_r[7:0];
         if (wr_go && aw_addr_r == DIV_LO_ADDR) div_lo_r <= w_data_r[7:0];
         if (wr_go && aw_addr_r == TX_CTRL_ADDR) begin
            tx_ctrl_r[7:2] <= w_data_r[7:2];
            tx_ctrl_r[0]   <= w_data_r[0];
         end
         if (wr_go && aw_addr_r == BAUD_CTRL_ADDR) begin
            baud_r[5:0] <= w_data_r[5:0];
         end
         if (bit_end && is_break_r && bit_cnt_r == bit_total_r - 5'h1)
            tx_ctrl_r[BREAK_BIT] <= 1'b0;
         tx_ctrl_r[SHIFT_EMPTY_BIT] <= (tx_state_r == TX_IDLE) && !load_now;
         baud_r[RX_IDLE_BIT] <= !wake_seen_r;
         if (wake_seen_r && rx_rise) baud_r[WAKE_EN_BIT] <= 1'b0;
      end
   end

   // Wake detect and receive flag
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wake_seen_r <= 1'b0;
         rx_flag_r   <= 1'b0;
         rx_buf_r    <= 8'h00;
      end else if (clk_en) begin
         if (wake_en && !wake_seen_r && rx_fall) begin
            wake_seen_r <= 1'b1;
            rx_flag_r   <= 1'b1;
         end else if (rd_buf_pulse) begin
            rx_flag_r <= 1'b0;
         end
         if (wake_seen_r && rx_rise) wake_seen_r <= 1'b0;
      end
   end

   // Transmit buffer and flag
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tx_buf_r      <= 8'h00;
         tx_buf_full_r <= 1'b0;
         tx_flag_r     <= 1'b0;
      end else if (clk_en) begin
         if (wr_buf_pulse) begin
            tx_buf_r      <= w_data_r[7:0];
            tx_buf_full_r <= 1'b1;
            tx_flag_r     <= 1'b0;
         end else if (load_now) begin
            tx_buf_full_r <= 1'b0;
            tx_flag_r     <= 1'b1;
         end else if (!tx_buf_full_r && tx_ctrl_r[TX_EN_BIT]) begin
            tx_flag_r <= 1'b1;
         end
      end
   end

   // Transmit shifter
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tx_state_r     <= TX_IDLE;
         tx_shift_reg_r <= 10'h3ff;
         bit_cnt_r      <= 5'h0;
         bit_total_r    <= CHAR_BITS;
         is_break_r     <= 1'b0;
         phase_r        <= 1'b0;
      end else if (clk_en) begin
         if (half_tick && tx_state_r == TX_SHIFT) phase_r <= !phase_r;
         if (load_now) begin
            tx_state_r <= TX_SHIFT;
            bit_cnt_r  <= 5'h0;
            phase_r    <= 1'b0;
            is_break_r <= send_brk;
            if (clocked_mode) begin
               tx_shift_reg_r <= {2'h3, tx_buf_r};
               bit_total_r    <= SYNC_BITS;
            end else if (send_brk) begin
               tx_shift_reg_r <= 10'h000;
               bit_total_r    <= BREAK_BITS;
            end else begin
               tx_shift_reg_r <= {1'b1, tx_buf_r, 1'b0};
               bit_total_r    <= CHAR_BITS;
            end
         end else if (bit_end) begin
            bit_cnt_r <= bit_cnt_r + 5'h1;
            tx_shift_reg_r <= (is_break_r && bit_cnt_r == BREAK_BITS - 5'h2)
                              ? 10'h3ff : {!is_break_r, tx_shift_reg_r[9:1]};
            if (bit_cnt_r == bit_total_r - 5'h1) tx_state_r <= TX_IDLE;
         end
      end
   end

   // Pin drivers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tx_pin             <= 1'b1;
         shift_clock_pin    <= 1'b0;
         data_line_pin_o    <= 1'b0;
         data_line_pin_oe_n <= 1'b1;
      end else if (clk_en) begin
         tx_pin <= clocked_mode ? 1'b1 : tx_shift_reg_r[0];
         // Shift clock leaves idle in first half, returns idle mid-bit
         shift_clock_pin <= (clocked_mode && tx_state_r == TX_SHIFT && !phase_r)
                            ? !idle_clk : idle_clk;
         data_line_pin_o <= (clocked_mode && tx_state_r == TX_SHIFT)
                            ? (tx_shift_reg_r[0] ^ idle_dat) : idle_dat;
         data_line_pin_oe_n <= !(clocked_mode && tx_state_r == TX_SHIFT);
      end
   end

   // AXI read
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0;
         s_axi_rresp   <= RESP_OKAY;
      end else if (clk_en) begin
         s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= known_addr(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            case (s_axi_araddr)
               RX_CTRL_ADDR:   s_axi_rdata <= {24'h0, rx_ctrl_r};
               RX_BUF_ADDR:    s_axi_rdata <= {24'h0, rx_buf_r};
               TX_BUF_ADDR:    s_axi_rdata <= {24'h0, tx_buf_r};
               TX_CTRL_ADDR:   s_axi_rdata <= {24'h0, tx_ctrl_r};
               BAUD_CTRL_ADDR: s_axi_rdata <= {24'h0, baud_r};
               DIV_HI_ADDR:    s_axi_rdata <= {24'h0, div_hi_r};
               DIV_LO_ADDR:    s_axi_rdata <= {24'h0, div_lo_r};
               FLAGS_ADDR:     s_axi_rdata <= {30'h0, tx_flag_r, rx_flag_r};
               default:        s_axi_rdata <= 32'h0;
            endcase
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
   assign rd_buf_pulse = clk_en && s_axi_arvalid && s_axi_arready
                         && s_axi_araddr == RX_BUF_ADDR;

   // Assertions
   sequence s_wake;
      baud_r[WAKE_EN_BIT] && !wake_seen_r && rx_fall && clk_en;
   endsequence
   property p_wake_flag;
      @(posedge aclk) disable iff (!aresetn) s_wake |=> rx_flag_r && wake_seen_r;
   endproperty
   a_wake_flag: assert property (p_wake_flag) else $error("wake flag not set");
   property p_wake_clear;
      @(posedge aclk) disable iff (!aresetn)
         (wake_seen_r && rx_rise && clk_en) |=> !baud_r[WAKE_EN_BIT];
   endproperty
   a_wake_clear: assert property (p_wake_clear) else $error("wake enable kept");
   property p_break_zero;
      @(posedge aclk) disable iff (!aresetn)
         (load_now && send_brk) |=> tx_shift_reg_r == 10'h000;
   endproperty
   a_break_zero: assert property (p_break_zero) else $error("break data not zero");
   property p_break_len;
      @(posedge aclk) disable iff (!aresetn)
         (load_now && send_brk) |=> bit_total_r == BREAK_BITS;
   endproperty
   a_break_len: assert property (p_break_len) else $error("break length wrong");
   property p_break_clr;
      @(posedge aclk) disable iff (!aresetn)
         (bit_end && clk_en && is_break_r && bit_cnt_r == bit_total_r - 5'h1)
         |=> !tx_ctrl_r[BREAK_BIT];
   endproperty
   a_break_clr: assert property (p_break_clr) else $error("break bit kept");
   property p_tx_flag;
      @(posedge aclk) disable iff (!aresetn) (load_now && !wr_buf_pulse) |=> tx_flag_r;
   endproperty
   a_tx_flag: assert property (p_tx_flag) else $error("tx flag not set");
   property p_empty;
      @(posedge aclk) disable iff (!aresetn)
         (tx_state_r == TX_SHIFT && clk_en) |=> !tx_ctrl_r[SHIFT_EMPTY_BIT];
   endproperty
   a_empty: assert property (p_empty) else $error("shift empty wrong");
   property p_half_duplex;
      @(posedge aclk) disable iff (!aresetn)
         (clk_en && wake_seen_r && tx_state_r == TX_IDLE) |=> tx_state_r == TX_IDLE;
   endproperty
   a_half_duplex: assert property (p_half_duplex) else $error("load while receiving");
endmodule : uart_wake_break_sync_master
`default_nettype wire

//--- src/uart_wake_pkg.sv
package uart_wake_pkg;
   // Register byte addresses
   localparam logic [7:0] RX_CTRL_ADDR   = 8'h00;
   localparam logic [7:0] RX_BUF_ADDR    = 8'h04;
   localparam logic [7:0] TX_BUF_ADDR    = 8'h08;
   localparam logic [7:0] TX_CTRL_ADDR   = 8'h0c;
   localparam logic [7:0] BAUD_CTRL_ADDR = 8'h10;
   localparam logic [7:0] DIV_HI_ADDR    = 8'h14;
   localparam logic [7:0] DIV_LO_ADDR    = 8'h18;
   localparam logic [7:0] FLAGS_ADDR     = 8'h1c;
   // tx_control_status fields
   localparam int CLK_SRC_BIT    = 7;
   localparam int TX_EN_BIT      = 5;
   localparam int CLOCKED_BIT    = 4;
   localparam int BREAK_BIT      = 3;
   localparam int SHIFT_EMPTY_BIT = 1;
   // rx_control_status fields
   localparam int PORT_EN_BIT    = 7;
   // baud_control fields
   localparam int RX_IDLE_BIT    = 6;
   localparam int DATA_POL_BIT   = 5;
   localparam int CLK_POL_BIT    = 4;
   localparam int WAKE_EN_BIT    = 1;
   // Flags register fields
   localparam int RX_FLAG_BIT    = 0;
   localparam int TX_FLAG_BIT    = 1;
   // Frame lengths in bit times
   localparam logic [4:0] BREAK_BITS = 5'h0e;
   localparam logic [4:0] CHAR_BITS  = 5'h0a;
   localparam logic [4:0] SYNC_BITS  = 5'h08;
   localparam logic [7:0] REG_RESET  = 8'h00;
   localparam logic [7:0] TX_CTRL_RESET = 8'h02;
   localparam logic [7:0] BAUD_RESET = 8'h40;
   localparam logic [1:0] RESP_OKAY  = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : uart_wake_pkg

//--- test/lin_peer_model.sv
`timescale 1ns/1ns
`default_nettype none
module lin_peer_model (
   // Clock
   input  wire logic aclk,
   // Pins of the block and the expected clock idle level
   input  wire logic tx_pin,
   input  wire logic shift_clock_pin,
   input  wire logic data_line_pin_o,
   input  wire logic data_line_pin_oe_n,
   input  wire logic clk_pol,
   // Shared receive and data wire
   output logic      rx_pin
);
   logic       rx_drv     = 1'b1;
   logic       ck_q       = 1'b0;
   logic [7:0] sync_byte  = 8'h00;
   int         sync_edges = 0;
   int         run        = 0;
   int         runs[$];

   // Block drives the wire while shifting in clocked mode, otherwise the peer does
   assign rx_pin = data_line_pin_oe_n ? rx_drv : data_line_pin_o;

   task automatic set_rx(input logic v);
      @(posedge aclk);
      rx_drv <= v;
   endtask : set_rx

   // Off the edge so the sampling process never races it
   task automatic clear();
      @(negedge aclk);
      sync_edges = 0;
      runs.delete();
   endtask : clear

   always @(posedge aclk) begin
      ck_q <= shift_clock_pin;
      if (tx_pin === 1'b0) begin
         run = run + 1;
      end else if (run != 0) begin
         runs.push_back(run);
         run = 0;
      end
      if (shift_clock_pin !== ck_q && shift_clock_pin === clk_pol) begin
         sync_byte <= {data_line_pin_o, sync_byte[7:1]};
         sync_edges = sync_edges + 1;
      end
   end
endmodule : lin_peer_model
`default_nettype wire

//--- test/test_uart_wake_break_sync_master.sv
`timescale 1ns/1ns
`default_nettype none
module test_uart_wake_break_sync_master;
   import uart_wake_pkg::*;
   localparam int DIV = 3;
   localparam int BIT = 2 * (DIV + 1);
   logic        aclk    = 1'b0;
   logic        aresetn = 1'b0;
   logic [7:0]  awaddr  = 8'h00;
   logic [7:0]  araddr  = 8'h00;
   logic [31:0] wdata   = 32'h0;
   logic        awvalid = 1'b0;
   logic        wvalid  = 1'b0;
   logic        bready  = 1'b0;
   logic        arvalid = 1'b0;
   logic        rready  = 1'b0;
   logic        clk_pol = 1'b0;
   logic        clk_en  = 1'b1;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [1:0]  bresp, rresp, rsp;
   logic [31:0] rdata, rd;
   logic        rx_pin, tx_pin, shift_clock_pin, data_o, data_oe_n;
   int          error_cnt   = 0;
   int          check_count = 0;
   int          cycles      = 0;

   always #10 aclk = ~aclk;

   uart_wake_break_sync_master u_dut (
      .aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .rx_pin(rx_pin),
      .tx_pin(tx_pin), .shift_clock_pin(shift_clock_pin),
      .data_line_pin_o(data_o), .data_line_pin_oe_n(data_oe_n)
   );

   lin_peer_model u_peer (
      .aclk(aclk), .tx_pin(tx_pin), .shift_clock_pin(shift_clock_pin),
      .data_line_pin_o(data_o), .data_line_pin_oe_n(data_oe_n),
      .clk_pol(clk_pol), .rx_pin(rx_pin)
   );

   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : wrap_up

   always @(posedge aclk) begin
      cycles <= cycles + 1;
      if (cycles == 6000) begin
         error_cnt = error_cnt + 1;
         wrap_up();
      end
   end

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      // Ends on bvalid; only the global timeout bounds this wait
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      rsp = bresp;
      bready <= 1'b0;
   endtask : wr

   task automatic rd_reg(input logic [7:0] a);
      @(posedge aclk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      rd = rdata;
      rsp = rresp;
      rready <= 1'b0;
   endtask : rd_reg

   // Bounded poll of one register bit
   task automatic poll(input logic [7:0] a, input int b, input logic v);
      int n;
      for (n = 0; n < 100; n++) begin
         rd_reg(a);
         if (rd[b] === v) break;
      end
   endtask : poll

   task automatic test_reset();
      rd_reg(TX_CTRL_ADDR);
      check("tx_control_status reset", {24'h0, TX_CTRL_RESET}, rd);
      rd_reg(BAUD_CTRL_ADDR);
      check("baud_control reset", {24'h0, BAUD_RESET}, rd);
      wr(TX_CTRL_ADDR, 32'h0);
      rd_reg(TX_CTRL_ADDR);
      check("shift_empty read only", {24'h0, TX_CTRL_RESET}, rd);
      rd_reg(8'h20);
      check("unmapped response", {30'h0, RESP_SLVERR}, {30'h0, rsp});
      $display("test_reset done");
   endtask : test_reset

   task automatic test_break();
      int i;
      wr(DIV_LO_ADDR, DIV);
      wr(RX_CTRL_ADDR, 32'h1 << PORT_EN_BIT);
      wr(TX_CTRL_ADDR, (32'h1 << TX_EN_BIT) | (32'h1 << BREAK_BIT));
      u_peer.clear();
      // Nonzero dummy proves the data value is ignored
      wr(TX_BUF_ADDR, 32'ha5);
      rd_reg(TX_CTRL_ADDR);
      check("shift_empty during break", 32'h0, rd[SHIFT_EMPTY_BIT]);
      wr(TX_BUF_ADDR, 32'h55);
      rd_reg(FLAGS_ADDR);
      check("tx_flag while queued", 32'h0, rd[TX_FLAG_BIT]);
      poll(TX_CTRL_ADDR, SHIFT_EMPTY_BIT, 1'b1);
      rd_reg(FLAGS_ADDR);
      check("tx_flag after load", 32'h1, rd[TX_FLAG_BIT]);
      rd_reg(TX_CTRL_ADDR);
      check("break_send cleared", 32'h22, rd);
      check("low runs", 32'd6, u_peer.runs.size());
      if (u_peer.runs.size() == 6) begin
         check("break low time", 13 * BIT, u_peer.runs[0]);
         for (i = 1; i < 6; i++) begin
            check("sync low time", BIT, u_peer.runs[i]);
         end
      end
      $display("test_break done");
   endtask : test_break

   task automatic test_wake();
      rd_reg(BAUD_CTRL_ADDR);
      check("idle before sleep", 32'h1, rd[RX_IDLE_BIT]);
      wr(BAUD_CTRL_ADDR, 32'h1 << WAKE_EN_BIT);
      rd_reg(BAUD_CTRL_ADDR);
      check("idle while watching", 32'h1, rd[RX_IDLE_BIT]);
      u_peer.set_rx(1'b0);
      repeat (4 * BIT) @(posedge aclk);
      rd_reg(FLAGS_ADDR);
      check("wake rx_flag", 32'h1, rd[RX_FLAG_BIT]);
      rd_reg(BAUD_CTRL_ADDR);
      check("wake held while low", 32'h1, rd[WAKE_EN_BIT]);
      check("break in progress", 32'h0, rd[RX_IDLE_BIT]);
      repeat (8 * BIT) @(posedge aclk);
      u_peer.set_rx(1'b1);
      poll(BAUD_CTRL_ADDR, WAKE_EN_BIT, 1'b0);
      check("wake cleared", 32'h0, rd[WAKE_EN_BIT]);
      // Dummy data, discarded
      rd_reg(RX_BUF_ADDR);
      rd_reg(FLAGS_ADDR);
      check("rx_flag cleared", 32'h0, rd[RX_FLAG_BIT]);
      $display("test_wake done");
   endtask : test_wake

   task automatic test_sync();
      int i;
      logic [2:0] hold;
      clk_pol <= 1'b1;
      wr(BAUD_CTRL_ADDR, 32'h1 << CLK_POL_BIT);
      wr(TX_CTRL_ADDR, (32'h1 << CLK_SRC_BIT) | (32'h1 << TX_EN_BIT) | (32'h1 << CLOCKED_BIT));
      u_peer.clear();
      check("clock idle high", 32'h1, shift_clock_pin);
      wr(TX_BUF_ADDR, 32'hc3);
      // Freeze mid-word: pins must hold and no clock edge may be lost
      repeat (2 * BIT) @(posedge aclk);
      clk_en <= 1'b0;
      @(posedge aclk);
      hold = {shift_clock_pin, data_o, data_oe_n};
      repeat (3 * BIT) @(posedge aclk);
      check("frozen pins", {29'h0, hold}, {29'h0, shift_clock_pin, data_o, data_oe_n});
      clk_en <= 1'b1;
      poll(TX_CTRL_ADDR, SHIFT_EMPTY_BIT, 1'b1);
      check("clocked byte", 32'hc3, u_peer.sync_byte);
      check("clock cycles", 32'd8, u_peer.sync_edges);
      for (i = 0; i < 4; i++) begin
         wr(BAUD_CTRL_ADDR, {26'h0, i[1], i[0], 4'h0});
         @(negedge aclk);
         check("clock idle level", i[0], shift_clock_pin);
         check("data idle level", i[1], data_o);
      end
      $display("test_sync done");
   endtask : test_sync

   initial begin
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      test_reset();
      test_break();
      test_wake();
      test_sync();
      wrap_up();
   end
endmodule : test_uart_wake_break_sync_master
`default_nettype wire
